// ===== bench/ldpwm_fixture_model.sv
// Far-side fixture: mains sync opto-coupler and reset push-button sharing one pin
`timescale 1ns/1ns
module ldpwm_fixture_model #(
    parameter int unsigned SYNC_GAP = 500
) (
    // Clock
    input  wire logic sys_clk,
    // Mains sync source running
    input  wire logic sync_on,
    // Shared sync/reset pin, pulled up whenever nobody sinks it
    output logic      hold_reset_pin
);
    logic opto_low   = 1'b0;
    logic button_low = 1'b0;
    int   gap        = 0;
    // Pull-up wins unless the opto-coupler or the button sinks the line
    assign hold_reset_pin = !(opto_low || button_low);
    // Short low pulse once per mains gap, stands still while the source is off
    always @(posedge sys_clk) begin
        gap <= (gap + 1) % SYNC_GAP;
        opto_low <= sync_on && (gap < 4);
    end
    // Button held low for n clocks; the series resistor lets it override the opto
    task automatic press(input int n);
        @(posedge sys_clk);
        #2 button_low = 1'b1;
        repeat (n) @(posedge sys_clk);
        #2 button_low = 1'b0;
    endtask
endmodule

// ===== bench/ldpwm_top_tb.sv
// Self-checking bench for the lighting dimming PWM block
`timescale 1ns/1ns
module ldpwm_top_tb;
    import ldpwm_pkg::*;
    // Short counts keep the run brief; the default-period and hold-time expectations derive from these
    localparam int T_HOLD = 50;
    localparam int T_PER  = 600;
    logic              sys_clk = 1'b0;
    logic              sys_rst = 1'b1;
    logic [1:0]        mode_strap = MODE_THREE;
    logic              hv_supply_high = 1'b1;
    logic [DIM_W-1:0]  dim_level_in = 10'h200;
    logic [DIM_W-1:0]  net_dim_level = 10'h100;
    logic              net_dim_valid = 1'b0;
    logic              net_dim_select = 1'b0;
    logic [DUTY_W-1:0] warm_share = 12'h800;
    logic              warm_on_two = 1'b1;
    logic [PER_W-1:0]  period_cfg = 16'h0000;
    logic              period_cfg_load = 1'b0;
    logic              aux_analog_sel = 1'b0;
    logic [DIM_W-1:0]  aux_level = 10'h300;
    logic              aux_digital = 1'b0;
    logic              aux_control_en = 1'b0;
    logic              sync_enable = 1'b0;
    logic              sync_on = 1'b0;
    logic              hold_reset_pin;
    logic              pwm_one, pwm_two, pwm_three, ext_divider_sel, sync_locked, hold_reset_req;
    logic [DUTY_W-1:0] analog_dim_out;
    logic [2:0]        pwm_bus;
    int                failures = 0;
    int                num_checks = 0;
    int                cyc = 0;
    int                a, b, c;
    logic [15:0]       n2, n3;
    assign pwm_bus = {pwm_three, pwm_two, pwm_one};
    // Clock and cycle count
    always #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk) cyc <= cyc + 1;
    ldpwm_top #(.HOLD_CYC(T_HOLD), .DEF_PER(T_PER)) u_ldpwm_top (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .mode_strap(mode_strap),
        .hv_supply_high(hv_supply_high), .dim_level_in(dim_level_in),
        .net_dim_level(net_dim_level), .net_dim_valid(net_dim_valid),
        .net_dim_select(net_dim_select), .warm_share(warm_share), .warm_on_two(warm_on_two),
        .period_cfg(period_cfg), .period_cfg_load(period_cfg_load),
        .aux_analog_sel(aux_analog_sel), .aux_level(aux_level), .aux_digital(aux_digital),
        .aux_control_en(aux_control_en), .sync_enable(sync_enable),
        .hold_reset_pin(hold_reset_pin), .pwm_one(pwm_one), .pwm_two(pwm_two),
        .pwm_three(pwm_three), .analog_dim_out(analog_dim_out),
        .ext_divider_sel(ext_divider_sel), .sync_locked(sync_locked),
        .hold_reset_req(hold_reset_req));
    ldpwm_fixture_model u_ldpwm_fixture_model (
        .sys_clk(sys_clk), .sync_on(sync_on), .hold_reset_pin(hold_reset_pin));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Inputs always move a fixed 2 ns after the rising edge
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask
    // Cycle number of the next rising edge on channel i, bounded wait
    task automatic rise(input int i, output int t);
        logic p;
        p = pwm_bus[i];
        t = -1;
        for (int k = 0; k < 12000 && t < 0; k++) begin
            step(1);
            if (pwm_bus[i] === 1'b1 && p === 1'b0) t = cyc;
            p = pwm_bus[i];
        end
    endtask
    // High cycles of channel i over one default period
    task automatic hi(input int i, output logic [15:0] n);
        n = 16'h0;
        repeat (T_PER) begin
            step(1);
            if (pwm_bus[i] === 1'b1) n++;
        end
    endtask
    task automatic dimcase(input logic [9:0] loc, input logic en, input logic dig,
                           input logic an, input logic [11:0] exp);
        dim_level_in = loc;
        aux_control_en = en;
        aux_digital = dig;
        aux_analog_sel = an;
        step(2 * T_PER + 10);
        check({4'h0, analog_dim_out}, {4'h0, exp});
    endtask
    task automatic t_periods;
        rise(0, a);
        rise(0, b);
        check(16'(b - a), 16'(T_PER));
        // Channel g runs g thirds ahead, so channel 2 rises first after channel 0
        rise(0, a);
        rise(2, c);
        rise(1, b);
        check(16'(c - a), 16'(T_PER / 3));
        check(16'(b - a), 16'(2 * T_PER / 3));
        // Load mid-period: the running period must finish at its old length
        rise(0, a);
        period_cfg = 16'd5000;
        period_cfg_load = 1'b1;
        step(1);
        period_cfg_load = 1'b0;
        rise(0, b);
        rise(0, c);
        check(16'(b - a), 16'(T_PER));
        check(16'(c - b), 16'd5000);
        period_cfg = 16'h0010;
        period_cfg_load = 1'b1;
        step(1);
        period_cfg_load = 1'b0;
        rise(0, a);
        rise(0, b);
        check(16'(b - a), 16'(PWM_MIN_CYC));
        // The floor lies above the short test period, so a second reset restores it
        sys_rst = 1'b1;
        step(1);
        sys_rst = 1'b0;
        check({pwm_bus, analog_dim_out, ext_divider_sel}, 16'h0001);
        rise(0, a);
        rise(0, b);
        check(16'(b - a), 16'(T_PER));
    endtask
    task automatic t_shares;
        // The warm/cool split only applies outside three-PWM mode
        mode_strap = MODE_ANALOG;
        for (int w = 0; w < 4; w++) begin
            warm_on_two = w[0];
            warm_share = w[1] ? 12'hfff : 12'h000;
            step(2 * T_PER + 10);
            hi(1, n2);
            hi(2, n3);
            check(n2, (w[0] == w[1]) ? 16'(T_PER) : 16'h0);
            check(n3, (w[0] != w[1]) ? 16'(T_PER) : 16'h0);
        end
    endtask
    task automatic t_dim;
        mode_strap = MODE_ANALOG;
        dimcase(10'h3ff, 1'b0, 1'b0, 1'b0, 12'hfff);
        dimcase(10'h200, 1'b0, 1'b0, 1'b0, 12'h802);
        dimcase(10'h000, 1'b0, 1'b0, 1'b0, DUTY_MIN_ANA);
        dimcase(10'h000, 1'b1, 1'b1, 1'b0, 12'hfff);
        dimcase(10'h3ff, 1'b1, 1'b0, 1'b0, DUTY_MIN_ANA);
        dimcase(10'h000, 1'b1, 1'b0, 1'b1, 12'hc03);
        net_dim_valid = 1'b1;
        step(1);
        net_dim_valid = 1'b0;
        net_dim_select = 1'b1;
        dimcase(10'h000, 1'b0, 1'b0, 1'b0, 12'h401);
        net_dim_select = 1'b0;
        mode_strap = MODE_THREE;
        step(2 * T_PER + 10);
        hi(0, n2);
        check({15'h0, n2 > 0 && n2 < 20}, 16'h1);
        mode_strap = MODE_TUNE;
        dim_level_in = 10'h3ff;
        step(2 * T_PER + 10);
        hi(0, n2);
        check(n2, 16'h0);
        hi(1, n3);
        check(n3, 16'(T_PER));
        // Tuning outputs follow the dimming level: fully dimmed means dark
        dim_level_in = 10'h000;
        step(2 * T_PER + 10);
        hi(1, n3);
        check(n3, 16'h0);
        mode_strap = MODE_THREE;
    endtask
    task automatic t_pin;
        sync_enable = 1'b1;
        sync_on = 1'b1;
        step(1500);
        check({15'h0, sync_locked}, 16'h1);
        sync_on = 1'b0;
        step(5 * T_PER + 100);
        check({15'h0, sync_locked}, 16'h0);
        u_ldpwm_fixture_model.press(T_HOLD - 10);
        check({15'h0, hold_reset_req}, 16'h0);
        fork
            u_ldpwm_fixture_model.press(T_HOLD + 20);
        join_none
        step(T_HOLD + 10);
        check({15'h0, hold_reset_req}, 16'h1);
        step(20);
        check({15'h0, hold_reset_req}, 16'h0);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Watchdog, well beyond the expected run of about 50000 cycles
    initial begin
        #(40 * 80000);
        failures++;
        tally_and_finish();
    end
    initial begin
        step(6);
        check({pwm_bus, analog_dim_out, ext_divider_sel}, 16'h0001);
        step(2);
        sys_rst = 1'b0;
        step(3);
        check({15'h0, ext_divider_sel}, 16'h0);
        hv_supply_high = 1'b0;
        step(3);
        check({15'h0, ext_divider_sel}, 16'h1);
        t_periods();
        t_shares();
        t_dim();
        t_pin();
        tally_and_finish();
    end
endmodule

// ===== hw/ldpwm_hold_reset.sv
// Detector for a long low pulse on the combined sync/reset pin
`timescale 1ns/1ns
module ldpwm_hold_reset
    import ldpwm_pkg::*;
#(
    parameter int unsigned HOLD_CYC = HOLD_RST_CYC
) (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    // Pin level and reset request
    input  wire logic hold_reset_pin,
    output logic      hold_reset_req
);
    logic [27:0] low_cnt;
    wire         low_long = (low_cnt >= 28'(HOLD_CYC));

    // Count cycles of low level; saturate once the threshold is reached
    always_ff @(posedge sys_clk) begin
        if (sys_rst || hold_reset_pin) begin
            low_cnt <= 28'h0;
        end else if (!low_long) begin
            low_cnt <= low_cnt + 28'h1;
        end
    end

    // Request stays high while the pin is held past the limit
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            hold_reset_req <= 1'b0;
        end else begin
            hold_reset_req <= low_long && !hold_reset_pin;
        end
    end

    AST_HOLD_RESET_LATE: assert property (@(posedge sys_clk) disable iff (sys_rst)
        hold_reset_req |-> $past(!hold_reset_pin))
        else $error("reset request without low pin");
endmodule

// ===== hw/ldpwm_pkg.sv
// Package with constants and types for the lighting dimming PWM block
package ldpwm_pkg;
    // Master clock rate in Hz
    localparam int unsigned CLK_HZ = 25000000;
    // Duty resolution and dimming input width
    localparam int DUTY_W = 12;
    localparam int DIM_W = 10;
    // Default PWM frequency after reset (Hz) and period count derived from it
    localparam int unsigned PWM_DEF_HZ = 888;
    localparam int unsigned PWM_DEF_CYC = CLK_HZ / PWM_DEF_HZ;
    // Highest PWM frequency (tenths of Hz) and shortest period in cycles
    localparam int unsigned PWM_MAX_DHZ = 53000;
    localparam int unsigned PWM_MIN_CYC = (CLK_HZ * 10 + PWM_MAX_DHZ - 1) / PWM_MAX_DHZ;
    localparam int PER_W = 16;
    // Duty fractions as 12-bit codes of full scale (4095)
    localparam logic [DUTY_W-1:0] DUTY_FULL = 12'hfff;
    localparam logic [DUTY_W-1:0] DUTY_MIN_ANA = 12'h19a;
    localparam logic [DUTY_W-1:0] DUTY_MIN_DIG = 12'h029;
    // Reset hold time on the sync/reset pin, in ms, and cycles derived
    localparam int unsigned HOLD_RST_MS = 100;
    localparam int unsigned HOLD_RST_CYC = CLK_HZ / 1000 * HOLD_RST_MS + 1;
    // Sync pin is declared absent after this many periods without edges
    localparam int unsigned SYNC_LOST_PER = 4;
    // Operating modes selected by the strap
    localparam logic [1:0] MODE_ANALOG = 2'h0;
    localparam logic [1:0] MODE_THREE = 2'h1;
    localparam logic [1:0] MODE_TUNE = 2'h2;
    // Dimming source selection
    typedef enum logic {LDPWM_SRC_LOCAL, LDPWM_SRC_NET} ldpwm_src_t;
endpackage

// ===== hw/ldpwm_top.sv
// Lighting output control: staggered PWMs, analogue dim level, sync and hold reset
//
// Notes on behaviour
// - Each PWM has 12-bit duty; period may be as short as 5.3 kHz allows.
// - After reset the PWM period corresponds to 888 Hz.
// - In three-PWM mode the PWMs share one duty; their edges are staggered in time.
// - Output one clamps to 10-100% analogue, 1-100% as PWM.
// - Outputs two and three span the full 0-100% duty range outside three-PWM mode.
// - The warm_on_two input decides which of outputs two and three drives warm.
// - Strap mode 0 analogue+2 PWM, 1 three PWM, 2 two dimmed tuning PWMs.
// - Dimming input is 10 bits, zero fully dimmed, all ones undimmed.
// - Dimming level comes from local input or network command.
// - PWMs optionally lock to sync; sync disables itself when pin floats.
// - Sync/reset pin low beyond 100 ms resets the device.
// - Internal or external divider chosen from the high-voltage supply level.
// - Auxiliary occupancy input analogue or digital, may drive the output directly.
// - All timing comes from the single master clock.
`timescale 1ns/1ns
module ldpwm_top
    import ldpwm_pkg::*;
#(
    parameter int unsigned HOLD_CYC = HOLD_RST_CYC,
    parameter int unsigned DEF_PER  = PWM_DEF_CYC
) (
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    // Strap and supply sensing
    input  wire logic [1:0]        mode_strap,
    input  wire logic              hv_supply_high,
    // Dimming sources
    input  wire logic [DIM_W-1:0]  dim_level_in,
    input  wire logic [DIM_W-1:0]  net_dim_level,
    input  wire logic              net_dim_valid,
    input  wire logic              net_dim_select,
    // Colour tuning: warm share (of the dimmed level in mode 2, of full scale in mode 0), and string wiring sense
    input  wire logic [DUTY_W-1:0] warm_share,
    input  wire logic              warm_on_two,
    // Period setting from configuration
    input  wire logic [PER_W-1:0]  period_cfg,
    input  wire logic              period_cfg_load,
    // Auxiliary occupancy input
    input  wire logic              aux_analog_sel,
    input  wire logic [DIM_W-1:0]  aux_level,
    input  wire logic              aux_digital,
    input  wire logic              aux_control_en,
    // Sync and reset pin
    input  wire logic              sync_enable,
    input  wire logic              hold_reset_pin,
    // Outputs
    output logic                   pwm_one,
    output logic                   pwm_two,
    output logic                   pwm_three,
    output logic [DUTY_W-1:0]      analog_dim_out,
    output logic                   ext_divider_sel,
    output logic                   sync_locked,
    output logic                   hold_reset_req
);
    // Internal reset combines the system reset with the long-low request
    logic core_rst;
    assign core_rst = sys_rst || hold_reset_req;

    ldpwm_hold_reset #(.HOLD_CYC(HOLD_CYC)) u_hold (
        .sys_clk        (sys_clk),
        .sys_rst        (sys_rst),
        .hold_reset_pin (hold_reset_pin),
        .hold_reset_req (hold_reset_req)
    );

    // Mode registered from the strap every cycle outside reset, so the strap is never loaded asynchronously
    logic [1:0] mode;
    always_ff @(posedge sys_clk) begin
        if (core_rst) begin
            mode <= MODE_THREE;
        end else begin
            mode <= (mode_strap == 2'h3) ? MODE_THREE : mode_strap;
        end
    end

    // Divider selection follows the high-voltage supply level
    always_ff @(posedge sys_clk) begin
        if (core_rst) begin
            ext_divider_sel <= 1'b1;
        end else begin
            ext_divider_sel <= !hv_supply_high;
        end
    end

    // Held network level; a new command replaces it
    logic [DIM_W-1:0] net_level;
    always_ff @(posedge sys_clk) begin
        if (core_rst) begin
            net_level <= {DIM_W{1'b1}};
        end else if (net_dim_valid) begin
            net_level <= net_dim_level;
        end
    end

    // Source and auxiliary selection, then widen 10 bits to 12
    ldpwm_src_t        src;
    logic [DIM_W-1:0]  aux_val;
    logic [DIM_W-1:0]  dim_sel;
    logic [DUTY_W-1:0] dim_wide;
    assign src      = net_dim_select ? LDPWM_SRC_NET : LDPWM_SRC_LOCAL;
    assign aux_val  = aux_analog_sel ? aux_level : {DIM_W{aux_digital}};
    assign dim_sel  = aux_control_en ? aux_val :
                      (src == LDPWM_SRC_NET) ? net_level : dim_level_in;
    // Zero input is fully dimmed, all ones undimmed; low bits replicate the top
    assign dim_wide = {dim_sel, dim_sel[DIM_W-1 -: 2]};

    // Clamp to a floor; a function because both the analogue and the PWM duties use it
    function automatic logic [DUTY_W-1:0] clamp_min(input logic [DUTY_W-1:0] v,
                                                    input logic [DUTY_W-1:0] lo);
        clamp_min = (v < lo) ? lo : v;
    endfunction

    // Scale a duty by a share (both 12 bits), keeping the top bits
    function automatic logic [DUTY_W-1:0] scale(input logic [DUTY_W-1:0] a,
                                                input logic [DUTY_W-1:0] b);
        logic [2*DUTY_W-1:0] p;
        p = a * b;
        scale = (b == DUTY_FULL) ? a : p[2*DUTY_W-1 -: DUTY_W];
    endfunction

    // Requested duties per output, by mode
    logic [DUTY_W-1:0] duty_ana;
    logic [DUTY_W-1:0] duty_dig;
    logic [DUTY_W-1:0] warm_d;
    logic [DUTY_W-1:0] cool_d;
    logic [DUTY_W-1:0] req1;
    logic [DUTY_W-1:0] req2;
    logic [DUTY_W-1:0] req3;
    assign duty_ana = clamp_min(dim_wide, DUTY_MIN_ANA);
    assign duty_dig = clamp_min(dim_wide, DUTY_MIN_DIG);
    // Tuning outputs are not floored, so 0% is reachable
    assign warm_d = (mode == MODE_TUNE) ? scale(dim_wide, warm_share) : warm_share;
    assign cool_d = (mode == MODE_TUNE) ? scale(dim_wide, DUTY_FULL - warm_share)
                                        : DUTY_FULL - warm_share;
    assign req1 = (mode == MODE_TUNE) ? 12'h000 : duty_dig;
    // Three-PWM mode shares one duty; otherwise the warm/cool split applies
    assign req2 = (mode == MODE_THREE) ? duty_dig :
                  (warm_on_two ? warm_d : cool_d);
    assign req3 = (mode == MODE_THREE) ? duty_dig :
                  (warm_on_two ? cool_d : warm_d);

    // Requested period, floored at the 5.3 kHz minimum
    logic [PER_W-1:0] per_req;
    always_ff @(posedge sys_clk) begin
        if (core_rst) begin
            per_req <= PER_W'(DEF_PER);
        end else if (period_cfg_load) begin
            per_req <= (period_cfg < PER_W'(PWM_MIN_CYC)) ? PER_W'(PWM_MIN_CYC)
                                                          : period_cfg;
        end
    end

    // Sync pin edge detection; pin shares the reset pin
    logic             sync_d;
    logic             sync_rise;
    logic [2:0]       lost_cnt;
    assign sync_rise = hold_reset_pin && !sync_d;
    always_ff @(posedge sys_clk) begin
        if (core_rst) begin
            sync_d <= 1'b1;
        end else begin
            sync_d <= hold_reset_pin;
        end
    end

    // Base counter and period boundary
    logic [PER_W-1:0] per_act;
    logic [PER_W-1:0] cnt;
    logic             per_end;
    logic             restart;
    assign per_end = (cnt >= per_act - PER_W'(1));
    // Restart early on a sync edge when locked; a floating pin never gives one
    assign restart = per_end || (sync_locked && sync_rise);

    always_ff @(posedge sys_clk) begin
        if (core_rst) begin
            cnt <= '0;
        end else begin
            cnt <= restart ? '0 : cnt + PER_W'(1);
        end
    end

    // Sync is considered present while edges keep coming
    always_ff @(posedge sys_clk) begin
        if (core_rst) begin
            lost_cnt <= 3'(SYNC_LOST_PER);
        end else if (sync_rise) begin
            lost_cnt <= '0;
        end else if (per_end && lost_cnt != 3'(SYNC_LOST_PER)) begin
            lost_cnt <= lost_cnt + 3'h1;
        end
    end
    assign sync_locked = sync_enable && (lost_cnt != 3'(SYNC_LOST_PER));

    // Shadow settings load only at the period boundary
    logic [DUTY_W-1:0] duty_act [3];
    logic [DUTY_W-1:0] req [3];
    logic [DUTY_W-1:0] ana_next;
    assign req[0] = req1;
    assign req[1] = req2;
    assign req[2] = req3;
    always_ff @(posedge sys_clk) begin
        if (core_rst) begin
            per_act <= PER_W'(DEF_PER);
        end else if (restart) begin
            per_act <= per_req;
        end
    end

    // Stagger each channel by a third of a period to spread switching
    logic [PER_W-1:0] third;
    assign third = per_act / PER_W'(3);
    logic [2:0] pwm_raw;
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_ch
            logic [PER_W-1:0] ofs;
            logic [PER_W-1:0] pos;
            logic [PER_W+DUTY_W-1:0] prod;
            logic [PER_W-1:0] hi_len;
            logic [PER_W:0]   sum;
            assign ofs = PER_W'(g) * third;
            // One bit wider, so a long period plus two thirds cannot wrap
            assign sum = {1'b0, cnt} + {1'b0, ofs};
            assign pos = (sum >= {1'b0, per_act}) ? PER_W'(sum - {1'b0, per_act})
                                                  : sum[PER_W-1:0];
            assign prod = per_act * duty_act[g];
            // Full scale means always high, zero means never high
            assign hi_len = (duty_act[g] == DUTY_FULL) ? per_act
                                                       : prod[PER_W+DUTY_W-1 -: PER_W];
            always_ff @(posedge sys_clk) begin
                if (core_rst) begin
                    duty_act[g] <= '0;
                end else if (restart) begin
                    duty_act[g] <= req[g];
                end
            end
            always_ff @(posedge sys_clk) begin
                if (core_rst) begin
                    pwm_raw[g] <= 1'b0;
                end else begin
                    pwm_raw[g] <= (pos < hi_len);
                end
            end
        end
    endgenerate

    // Output one is analogue in mode 0 and unused in mode 2
    assign pwm_one   = (mode == MODE_THREE) && pwm_raw[0];
    assign pwm_two   = pwm_raw[1];
    assign pwm_three = pwm_raw[2];
    assign ana_next  = (mode == MODE_ANALOG) ? duty_ana : 12'h000;

    always_ff @(posedge sys_clk) begin
        if (core_rst) begin
            analog_dim_out <= '0;
        end else if (restart) begin
            analog_dim_out <= ana_next;
        end
    end

    AST_PWM_ONE_OFF: assert property (@(posedge sys_clk) disable iff (core_rst)
        (mode != MODE_THREE) |-> !pwm_one)
        else $error("output one toggles outside three-PWM mode");
    AST_ANA_FLOOR: assert property (@(posedge sys_clk) disable iff (sys_rst)
        ($past(mode) == MODE_ANALOG && $past(restart) && !$past(core_rst))
            |-> analog_dim_out >= DUTY_MIN_ANA)
        else $error("analogue level below floor");
    AST_DUTY_HOLD: assert property (@(posedge sys_clk) disable iff (core_rst)
        !$past(core_rst) && !$past(restart) |-> $stable(duty_act[0]))
        else $error("duty changed mid-period");
    AST_PER_MIN: assert property (@(posedge sys_clk) disable iff (core_rst)
        per_act >= PER_W'(PWM_MIN_CYC) || per_act == PER_W'(DEF_PER))
        else $error("period shorter than minimum");
    AST_SAME_DUTY: assert property (@(posedge sys_clk) disable iff (core_rst)
        (mode == MODE_THREE) |-> req[1] == req[2] && req[0] == req[1])
        else $error("three-PWM duties differ");
    AST_CNT_WRAP: assert property (@(posedge sys_clk) disable iff (core_rst)
        per_end && !$past(core_rst) |=> cnt == '0)
        else $error("counter did not wrap");
    AST_DIV_SEL: assert property (@(posedge sys_clk) disable iff (core_rst)
        !hv_supply_high ##1 !core_rst |-> ext_divider_sel)
        else $error("divider select wrong");
    AST_NO_SYNC: assert property (@(posedge sys_clk) disable iff (core_rst)
        !sync_enable |-> !sync_locked)
        else $error("locked while sync disabled");
    // Output levels follow the loaded duty one cycle later
    AST_ZERO_LOW: assert property (@(posedge sys_clk) disable iff (core_rst)
        (duty_act[1] == '0) |=> !pwm_two)
        else $error("output two high at zero duty");
    AST_FULL_HIGH: assert property (@(posedge sys_clk) disable iff (core_rst)
        (duty_act[2] == DUTY_FULL) |=> pwm_three)
        else $error("output three low at full duty");
    AST_SYNC_RESTART: assert property (@(posedge sys_clk) disable iff (core_rst)
        (sync_locked && sync_rise) |=> cnt == '0)
        else $error("sync edge did not restart the period");
endmodule
